//--- core/uart_fifo_pkg.sv
// constants shared by the fifo control block and its fifo store
package uart_fifo_pkg;
    localparam int unsigned DATA_W  = 8;
    localparam int unsigned DEPTH   = 32;
    localparam int unsigned PTR_W   = 5;
    localparam int unsigned COUNT_W = 6;
    localparam int unsigned ADDR_W  = 3;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_DATA        = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_FIFO_CTRL   = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_INT_STATUS  = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_INT_MASK    = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_RX_LEVEL    = 3'h4;
    localparam logic [ADDR_W-1:0] OFS_TX_LEVEL    = 3'h5;
    localparam logic [ADDR_W-1:0] OFS_MODE_STATUS = 3'h6;

    // fifo_control field positions
    localparam int unsigned FC_ENABLE   = 0;
    localparam int unsigned FC_RX_RESET = 1;
    localparam int unsigned FC_TX_RESET = 2;
    localparam int unsigned FC_DMA_MODE = 3;
    localparam int unsigned FC_TX_TRIG  = 4;
    localparam int unsigned FC_RX_TRIG  = 6;

    // interrupt status and mask bit positions
    localparam int unsigned INT_W          = 3;
    localparam int unsigned INT_RX_TRIG    = 0;
    localparam int unsigned INT_TX_LOW     = 1;
    localparam int unsigned INT_RX_OVERRUN = 2;

    // receive trigger levels by field code
    localparam logic [COUNT_W-1:0] RX_TRIG_00 = 6'h08;
    localparam logic [COUNT_W-1:0] RX_TRIG_01 = 6'h10;
    localparam logic [COUNT_W-1:0] RX_TRIG_10 = 6'h18;
    localparam logic [COUNT_W-1:0] RX_TRIG_11 = 6'h1c;
    // transmit trigger levels by field code
    localparam logic [COUNT_W-1:0] TX_TRIG_00 = 6'h10;
    localparam logic [COUNT_W-1:0] TX_TRIG_01 = 6'h08;
    localparam logic [COUNT_W-1:0] TX_TRIG_10 = 6'h18;
    localparam logic [COUNT_W-1:0] TX_TRIG_11 = 6'h1e;
    // with fifos off each side is a single holding register
    localparam logic [COUNT_W-1:0] HOLD_TRIG  = 6'h01;
    localparam logic [COUNT_W-1:0] COUNT_ZERO = 6'h00;

    // reset values
    localparam logic [1:0]        RST_TRIG_SEL = 2'h0;
    localparam logic [INT_W-1:0]  RST_INT      = 3'h0;
    localparam logic [DATA_W-1:0] RST_DATA     = 8'h00;

    typedef enum logic {
        DMA_SINGLE,
        DMA_BLOCK
    } dma_mode_e;
endpackage : uart_fifo_pkg

//--- core/uart_fifo_store.sv
// flip-flop fifo with fill count, used for both receive and transmit
module uart_fifo_store #(
    parameter int unsigned W  = uart_fifo_pkg::DATA_W,
    parameter int unsigned D  = uart_fifo_pkg::DEPTH,
    parameter int unsigned PW = uart_fifo_pkg::PTR_W,
    parameter int unsigned CW = uart_fifo_pkg::COUNT_W
) (
    input  wire logic          clk_i,
    input  wire logic          rst_b_i,
    input  wire logic          ce_i,
    input  wire logic          flush_i,
    input  wire logic          push_i,
    input  wire logic [W-1:0]  push_data_i,
    input  wire logic          pop_i,
    output logic      [W-1:0]  head_o,
    output logic      [CW-1:0] count_o,
    output logic               full_o,
    output logic               empty_o
);
    logic [W-1:0]  mem_q [D], mem_d [D];
    logic [PW-1:0] wr_q, wr_d;
    logic [PW-1:0] rd_q, rd_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic          do_push, do_pop;

    assign full_o  = (cnt_q == CW'(D));
    assign empty_o = (cnt_q == '0);
    assign head_o  = mem_q[rd_q];
    assign count_o = cnt_q;

    always_comb begin
        do_push = push_i && !full_o;
        do_pop  = pop_i && !empty_o;
        mem_d   = mem_q;
        wr_d    = wr_q;
        rd_d    = rd_q;
        cnt_d   = cnt_q;
        if (flush_i) begin
            wr_d  = '0;
            rd_d  = '0;
            cnt_d = '0;
        end else begin
            if (do_push) begin
                mem_d[wr_q] = push_data_i;
                wr_d        = wr_q + PW'(1);
            end
            if (do_pop) begin
                rd_d = rd_q + PW'(1);
            end
            if (do_push && !do_pop) begin
                cnt_d = cnt_q + CW'(1);
            end else if (do_pop && !do_push) begin
                cnt_d = cnt_q - CW'(1);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mem_q <= '{default: '0};
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (ce_i) begin
            mem_q <= mem_d;
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end
endmodule : uart_fifo_store

//--- core/uart_fifo_ctrl.sv
// fifo control of one uart channel: trigger levels, dma request pins, fifo interrupts
//
// Summary of operation
// - control bit 3 picks dma mode 0 (single, default) or 1 (block).
// - in mode 0 the tx request pin is low while no tx data is held.
// - in mode 0 the rx request pin is low while rx data is held.
// - the rx trigger interrupt rises when the rx count reaches its trigger.
// - reception goes on past the trigger until the fifo is full.
// - in mode 1 the rx request pin is low while the rx count is at its trigger or more.
// - control bits 7-6 select the rx trigger, bit 7 the msb.
// - control bits 5-4 select the tx trigger, 16 when cleared.
// - the tx low interrupt rises when the tx count drops below its trigger.
// - rx trigger codes 00 to 11 give 8, 16, 24 and 28 characters.
// - tx trigger codes 00 to 11 give 16, 8, 24 and 30 characters.
// - a control write with enable clear keeps the other fields and flushes both fifos if they were on.
// - in mode 1 the tx request pin is high when full and low below the trigger.
//
// The strobed register port and the register offsets were chosen for this implementation.
module uart_fifo_ctrl (
    input  wire logic                               CLK_I,
    input  wire logic                               RST_B_I,
    input  wire logic                               CE_I,
    input  wire logic [uart_fifo_pkg::ADDR_W-1:0]   ADDR_I,
    input  wire logic [uart_fifo_pkg::DATA_W-1:0]   WDATA_I,
    input  wire logic                               WR_I,
    input  wire logic                               RD_I,
    output logic      [uart_fifo_pkg::DATA_W-1:0]   RDATA_O,
    input  wire logic [uart_fifo_pkg::DATA_W-1:0]   RX_CHAR_I,
    input  wire logic                               RX_VALID_I,
    input  wire logic                               RX_TIMEOUT_I,
    output logic      [uart_fifo_pkg::DATA_W-1:0]   TX_CHAR_O,
    output logic                                    TX_VALID_O,
    input  wire logic                               TX_TAKE_I,
    output logic                                    TX_SPACE_REQUEST_B_O,
    output logic                                    RX_DATA_REQUEST_B_O,
    output logic                                    IRQ_O
);
    localparam int unsigned DW = uart_fifo_pkg::DATA_W;
    localparam int unsigned CW = uart_fifo_pkg::COUNT_W;
    localparam int unsigned IW = uart_fifo_pkg::INT_W;

    // control register state
    logic                     fifo_en_q, fifo_en_d;
    uart_fifo_pkg::dma_mode_e mode_q, mode_d;
    logic [1:0]               rx_sel_q, rx_sel_d;
    logic [1:0]               tx_sel_q, tx_sel_d;
    logic                     rx_flush;
    logic                     tx_flush;

    // fifo side
    logic [DW-1:0] rx_head;
    logic [CW-1:0] rx_count;
    logic          rx_full;
    logic          rx_empty;
    logic          rx_full_eff;
    logic          rx_push;
    logic          rx_pop;
    logic [DW-1:0] tx_head;
    logic [CW-1:0] tx_count;
    logic          tx_full;
    logic          tx_empty;
    logic          tx_full_eff;
    logic          tx_push;
    logic          tx_pop;
    logic [CW-1:0] rx_trig;
    logic [CW-1:0] tx_trig;
    logic          block_mode;

    // transmit output stage
    logic [DW-1:0] tx_char_q, tx_char_d;
    logic          tx_valid_q, tx_valid_d;

    // interrupt state
    logic          rx_hit_q, rx_hit_d;
    logic          tx_low_q, tx_low_d;
    logic [IW-1:0] int_status_q;
    logic [IW-1:0] int_status_d;
    logic [IW-1:0] int_mask_q;
    logic [IW-1:0] int_mask_d;
    logic [IW-1:0] int_event;
    logic [IW-1:0] int_clear;
    logic          irq_q, irq_d;

    // pin and read data registers
    logic          tx_req_b_q, tx_req_b_d;
    logic          rx_req_b_q, rx_req_b_d;
    logic [DW-1:0] rdata_q;
    logic [DW-1:0] rdata_d;

    logic wr_data;
    logic wr_ctrl;
    logic rd_data;

    assign wr_data = WR_I && (ADDR_I == uart_fifo_pkg::OFS_DATA);
    assign wr_ctrl = WR_I && (ADDR_I == uart_fifo_pkg::OFS_FIFO_CTRL);
    assign rd_data = RD_I && (ADDR_I == uart_fifo_pkg::OFS_DATA);

    // control register: fields change only beside enable
    always_comb begin
        fifo_en_d = fifo_en_q;
        mode_d    = mode_q;
        rx_sel_d  = rx_sel_q;
        tx_sel_d  = tx_sel_q;
        rx_flush  = 1'b0;
        tx_flush  = 1'b0;
        if (wr_ctrl) begin
            if (WDATA_I[uart_fifo_pkg::FC_ENABLE]) begin
                fifo_en_d = 1'b1;
                mode_d    = WDATA_I[uart_fifo_pkg::FC_DMA_MODE] ? uart_fifo_pkg::DMA_BLOCK
                                                                : uart_fifo_pkg::DMA_SINGLE;
                rx_sel_d  = WDATA_I[uart_fifo_pkg::FC_RX_TRIG +: 2];
                tx_sel_d  = WDATA_I[uart_fifo_pkg::FC_TX_TRIG +: 2];
                // switching depth with data inside would corrupt the count
                rx_flush  = WDATA_I[uart_fifo_pkg::FC_RX_RESET] || !fifo_en_q;
                tx_flush  = WDATA_I[uart_fifo_pkg::FC_TX_RESET] || !fifo_en_q;
            end else begin
                fifo_en_d = 1'b0;
                rx_flush  = fifo_en_q;
                tx_flush  = fifo_en_q;
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            fifo_en_q <= 1'b0;
            mode_q    <= uart_fifo_pkg::DMA_SINGLE;
            rx_sel_q  <= uart_fifo_pkg::RST_TRIG_SEL;
            tx_sel_q  <= uart_fifo_pkg::RST_TRIG_SEL;
        end else if (CE_I) begin
            fifo_en_q <= fifo_en_d;
            mode_q    <= mode_d;
            rx_sel_q  <= rx_sel_d;
            tx_sel_q  <= tx_sel_d;
        end
    end

    // fifos off: both sides are one-character holding registers
    always_comb begin
        unique case (rx_sel_q)
            2'h0: rx_trig = uart_fifo_pkg::RX_TRIG_00;
            2'h1: rx_trig = uart_fifo_pkg::RX_TRIG_01;
            2'h2: rx_trig = uart_fifo_pkg::RX_TRIG_10;
            2'h3: rx_trig = uart_fifo_pkg::RX_TRIG_11;
        endcase
        unique case (tx_sel_q)
            2'h0: tx_trig = uart_fifo_pkg::TX_TRIG_00;
            2'h1: tx_trig = uart_fifo_pkg::TX_TRIG_01;
            2'h2: tx_trig = uart_fifo_pkg::TX_TRIG_10;
            2'h3: tx_trig = uart_fifo_pkg::TX_TRIG_11;
        endcase
        if (!fifo_en_q) begin
            rx_trig = uart_fifo_pkg::HOLD_TRIG;
            tx_trig = uart_fifo_pkg::HOLD_TRIG;
        end
    end

    assign block_mode  = fifo_en_q && (mode_q == uart_fifo_pkg::DMA_BLOCK);
    assign rx_full_eff = fifo_en_q ? rx_full : !rx_empty;
    assign tx_full_eff = fifo_en_q ? tx_full : !tx_empty;
    // reception continues past the trigger and stops only when full
    assign rx_push     = RX_VALID_I && !rx_full_eff;
    assign rx_pop      = rd_data;
    assign tx_push     = wr_data && !tx_full_eff;
    assign tx_pop      = (!tx_valid_q || TX_TAKE_I) && !tx_empty;

    uart_fifo_store u_rx_fifo (
        .clk_i       (CLK_I),
        .rst_b_i     (RST_B_I),
        .ce_i        (CE_I),
        .flush_i     (rx_flush),
        .push_i      (rx_push),
        .push_data_i (RX_CHAR_I),
        .pop_i       (rx_pop),
        .head_o      (rx_head),
        .count_o     (rx_count),
        .full_o      (rx_full),
        .empty_o     (rx_empty)
    );

    uart_fifo_store u_tx_fifo (
        .clk_i       (CLK_I),
        .rst_b_i     (RST_B_I),
        .ce_i        (CE_I),
        .flush_i     (tx_flush),
        .push_i      (tx_push),
        .push_data_i (WDATA_I),
        .pop_i       (tx_pop),
        .head_o      (tx_head),
        .count_o     (tx_count),
        .full_o      (tx_full),
        .empty_o     (tx_empty)
    );

    // stage toward the tx shifter; a flush leaves it alone
    always_comb begin
        tx_valid_d = tx_valid_q && !TX_TAKE_I;
        tx_char_d  = tx_char_q;
        if (tx_pop) begin
            tx_valid_d = 1'b1;
            tx_char_d  = tx_head;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            tx_valid_q <= 1'b0;
            tx_char_q  <= uart_fifo_pkg::RST_DATA;
        end else if (CE_I) begin
            tx_valid_q <= tx_valid_d;
            tx_char_q  <= tx_char_d;
        end
    end

    // sticky interrupts; a new event beats a same-cycle clear
    always_comb begin
        rx_hit_d  = (rx_count >= rx_trig);
        tx_low_d  = (tx_count < tx_trig);
        int_event = '0;
        int_event[uart_fifo_pkg::INT_RX_TRIG]    = rx_hit_d && !rx_hit_q;
        int_event[uart_fifo_pkg::INT_TX_LOW]     = tx_low_d && !tx_low_q;
        int_event[uart_fifo_pkg::INT_RX_OVERRUN] = RX_VALID_I && rx_full_eff;
        int_clear = (WR_I && (ADDR_I == uart_fifo_pkg::OFS_INT_STATUS)) ? WDATA_I[IW-1:0] : '0;
        int_mask_d = int_mask_q;
        if (WR_I && (ADDR_I == uart_fifo_pkg::OFS_INT_MASK)) begin
            int_mask_d = WDATA_I[IW-1:0];
        end
        int_status_d = (int_status_q & ~int_clear) | int_event;
        irq_d        = |(int_status_d & int_mask_d);
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rx_hit_q     <= 1'b0;
            tx_low_q     <= 1'b1;
            int_status_q <= uart_fifo_pkg::RST_INT;
            int_mask_q   <= uart_fifo_pkg::RST_INT;
            irq_q        <= 1'b0;
        end else if (CE_I) begin
            rx_hit_q     <= rx_hit_d;
            tx_low_q     <= tx_low_d;
            int_status_q <= int_status_d;
            int_mask_q   <= int_mask_d;
            irq_q        <= irq_d;
        end
    end

    // request pins and read data
    always_comb begin
        if (block_mode) begin
            tx_req_b_d = tx_req_b_q;
            if (tx_full) begin
                tx_req_b_d = 1'b1;
            end else if (tx_count < tx_trig) begin
                tx_req_b_d = 1'b0;
            end
            rx_req_b_d = rx_req_b_q;
            if ((rx_count >= rx_trig) || (RX_TIMEOUT_I && !rx_empty)) begin
                rx_req_b_d = 1'b0;
            end else if (rx_empty) begin
                rx_req_b_d = 1'b1;
            end
        end else begin
            tx_req_b_d = !tx_empty;
            rx_req_b_d = rx_empty;
        end
        rdata_d = '0;
        if (RD_I) begin
            unique case (ADDR_I)
                uart_fifo_pkg::OFS_DATA: rdata_d = rx_empty ? '0 : rx_head;
                uart_fifo_pkg::OFS_INT_STATUS: rdata_d = DW'(int_status_q);
                uart_fifo_pkg::OFS_INT_MASK: rdata_d = DW'(int_mask_q);
                uart_fifo_pkg::OFS_RX_LEVEL: rdata_d = DW'(rx_count);
                uart_fifo_pkg::OFS_TX_LEVEL: rdata_d = DW'(tx_count);
                uart_fifo_pkg::OFS_MODE_STATUS: rdata_d = {rx_sel_q, tx_sel_q,
                    mode_q == uart_fifo_pkg::DMA_BLOCK,
                    !rx_req_b_q, !tx_req_b_q, fifo_en_q};
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            tx_req_b_q <= 1'b0;
            rx_req_b_q <= 1'b1;
            rdata_q    <= uart_fifo_pkg::RST_DATA;
        end else if (CE_I) begin
            tx_req_b_q <= tx_req_b_d;
            rx_req_b_q <= rx_req_b_d;
            rdata_q    <= rdata_d;
        end
    end

    assign RDATA_O              = rdata_q;
    assign TX_CHAR_O            = tx_char_q;
    assign TX_VALID_O           = tx_valid_q;
    assign TX_SPACE_REQUEST_B_O = tx_req_b_q;
    assign RX_DATA_REQUEST_B_O  = rx_req_b_q;
    assign IRQ_O                = irq_q;
endmodule : uart_fifo_ctrl

//--- tb/uart_fifo_ctrl_monitor.sv
// concurrent checks on the pins of the fifo control block
module uart_fifo_ctrl_monitor (
    input wire logic       CLK_I,
    input wire logic       RST_B_I,
    input wire logic       CE_I,
    input wire logic [2:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic       WR_I,
    input wire logic       RD_I,
    input wire logic [7:0] RDATA_O,
    input wire logic [7:0] TX_CHAR_O,
    input wire logic       TX_VALID_O,
    input wire logic       TX_TAKE_I,
    input wire logic       TX_SPACE_REQUEST_B_O,
    input wire logic       RX_DATA_REQUEST_B_O,
    input wire logic       IRQ_O
);
    localparam logic [5:0] RXT [4] = '{6'h08, 6'h10, 6'h18, 6'h1c};
    localparam logic [5:0] TXT [4] = '{6'h10, 6'h08, 6'h18, 6'h1e};
    logic [4:0] ctl_q, ctl_d;
    logic       en_q, en_d, rd_q;
    logic [2:0] ra_q;
    logic       blk, rxl, txl;
    always_comb begin
        en_d  = en_q;
        ctl_d = ctl_q;
        if (CE_I && WR_I && ADDR_I == uart_fifo_pkg::OFS_FIFO_CTRL) begin
            en_d = WDATA_I[0];
            // a write with enable clear keeps the stored fields
            if (WDATA_I[0]) begin
                ctl_d = WDATA_I[7:3];
            end
        end
    end
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            en_q  <= 1'b0;
            ctl_q <= 5'h00;
            rd_q  <= 1'b0;
            ra_q  <= 3'h0;
        end else begin
            en_q  <= en_d;
            ctl_q <= ctl_d;
            rd_q  <= CE_I && RD_I;
            ra_q  <= ADDR_I;
        end
    end
    assign blk = en_q && ctl_q[0];
    assign rxl = rd_q && ra_q == uart_fifo_pkg::OFS_RX_LEVEL;
    assign txl = rd_q && ra_q == uart_fifo_pkg::OFS_TX_LEVEL;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    a_rdata_idle: assert property (!(CE_I && RD_I) |=> RDATA_O == 8'h00)
        else $error("stray read data");
    a_ctrl_write_only: assert property (rd_q && ra_q == uart_fifo_pkg::OFS_FIFO_CTRL
        |-> RDATA_O == 8'h00) else $error("control read nonzero");
    a_mode_readback: assert property (rd_q && ra_q == uart_fifo_pkg::OFS_MODE_STATUS
        |-> RDATA_O[7:4] == ctl_q[4:1] && RDATA_O[0] == en_q) else $error("mode fields wrong");
    a_tx_req_single: assert property (txl && !blk
        |-> TX_SPACE_REQUEST_B_O == (RDATA_O != 8'h00)) else $error("tx req mode 0");
    a_rx_req_single: assert property (rxl && !blk
        |-> RX_DATA_REQUEST_B_O == (RDATA_O == 8'h00)) else $error("rx req mode 0");
    a_tx_full_high: assert property (txl && blk && RDATA_O == 8'h20
        |-> TX_SPACE_REQUEST_B_O) else $error("tx req low when full");
    a_tx_below_low: assert property (txl && blk && RDATA_O < {2'h0, TXT[ctl_q[2:1]]}
        |-> !TX_SPACE_REQUEST_B_O) else $error("tx req high below trig");
    a_rx_trig_low: assert property (rxl && blk && RDATA_O >= {2'h0, RXT[ctl_q[4:3]]}
        |-> !RX_DATA_REQUEST_B_O) else $error("rx req high at trig");
    a_rx_empty_high: assert property (rxl && blk && RDATA_O == 8'h00
        |-> RX_DATA_REQUEST_B_O) else $error("rx req low when empty");
    a_level_depth: assert property (rxl || txl |-> RDATA_O <= 8'h20)
        else $error("fill count above depth");
    a_stage_holds: assert property (TX_VALID_O && !(CE_I && TX_TAKE_I)
        |=> TX_VALID_O && $stable(TX_CHAR_O)) else $error("tx stage changed untaken");
    a_irq_masked: assert property (CE_I && WR_I && ADDR_I == uart_fifo_pkg::OFS_INT_MASK
        && WDATA_I[2:0] == 3'h0 |-> ##2 !IRQ_O) else $error("interrupt with all masked");
endmodule : uart_fifo_ctrl_monitor

bind uart_fifo_ctrl uart_fifo_ctrl_monitor u_mon (.*);

//--- tb/uart_serial_side.sv
// stand-in for the serial shifters: feeds received characters, takes transmit ones
module uart_serial_side (
    input  wire logic       clk_i,
    input  wire logic [7:0] tx_char_i,
    input  wire logic       tx_valid_i,
    input  wire logic       drain_i,
    output logic            tx_take_o,
    output logic      [7:0] rx_char_o,
    output logic            rx_valid_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] taken [$];
    int         owed = 0;
    initial begin
        tx_take_o  = 1'b0;
        rx_char_o  = 8'h00;
        rx_valid_o = 1'b0;
    end
    // takes never abut, so each freshly loaded stage is seen first
    always @(posedge clk_i) begin
        if (tx_take_o) begin
            taken.push_back(tx_char_i);
        end
        tx_take_o <= tx_valid_i && !tx_take_o && (drain_i || owed > 0);
        if (tx_valid_i && !tx_take_o && owed > 0) begin
            owed <= owed - 1;
        end
    end
    task automatic send(input logic [7:0] c);
        @(posedge clk_i);
        rx_char_o  <= c;
        rx_valid_o <= 1'b1;
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_char_o  <= ~c;
    endtask : send
    task automatic take(input int n);
        owed += n;
    endtask : take
endmodule : uart_serial_side

//--- tb/uart_fifo_ctrl_bench.sv
// self-checking bench for the fifo control block
module uart_fifo_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam DAT = uart_fifo_pkg::OFS_DATA;
    localparam FC  = uart_fifo_pkg::OFS_FIFO_CTRL;
    localparam ST  = uart_fifo_pkg::OFS_INT_STATUS;
    localparam MSK = uart_fifo_pkg::OFS_INT_MASK;
    localparam RXL = uart_fifo_pkg::OFS_RX_LEVEL;
    localparam TXL = uart_fifo_pkg::OFS_TX_LEVEL;
    localparam MS  = uart_fifo_pkg::OFS_MODE_STATUS;
    localparam logic [7:0] RXT [4] = '{8'h08, 8'h10, 8'h18, 8'h1c};
    localparam logic [7:0] TXT [4] = '{8'h10, 8'h08, 8'h18, 8'h1e};
    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       drain = 1'b0;
    logic       rx_to = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata, rx_char, tx_char;
    logic       rx_valid, tx_valid, tx_take, tx_req_b, rx_req_b, irq;
    int         n_fail = 0;
    int         total_checks = 0;
    always #10 clk = ~clk;
    uart_fifo_ctrl u_dut (
        .CLK_I(clk), .RST_B_I(rst_b), .CE_I(1'b1), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .RX_CHAR_I(rx_char), .RX_VALID_I(rx_valid),
        .RX_TIMEOUT_I(rx_to), .TX_CHAR_O(tx_char), .TX_VALID_O(tx_valid), .TX_TAKE_I(tx_take),
        .TX_SPACE_REQUEST_B_O(tx_req_b), .RX_DATA_REQUEST_B_O(rx_req_b), .IRQ_O(irq)
    );
    uart_serial_side u_far (
        .clk_i(clk), .tx_char_i(tx_char), .tx_valid_i(tx_valid), .drain_i(drain),
        .tx_take_o(tx_take), .rx_char_o(rx_char), .rx_valid_o(rx_valid)
    );
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic chk_reg(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e,
                           input string what);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(what, e, rdata & m);
    endtask : chk_reg
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    task automatic feed(input int n, input logic [7:0] base);
        for (int i = 0; i < n; i++) u_far.send(base + 8'(i));
    endtask : feed
    // bounded wait for owed takes and, if asked, an empty stage
    task automatic wait_idle(input bit need_empty);
        int q = 0;
        for (int i = 0; i < 1000 && q < 4; i++) begin
            @(posedge clk);
            q = (u_far.owed > 0 || (need_empty && tx_valid)) ? 0 : q + 1;
        end
        if (q < 4) begin
            n_fail++;
            give_verdict();
        end
    endtask : wait_idle
    task automatic t_reset;
        chk("tx_req_b", 8'h00, {7'h0, tx_req_b});
        chk("rx_req_b", 8'h01, {7'h0, rx_req_b});
        chk("irq", 8'h00, {7'h0, irq});
        chk_reg(MS, 8'hf9, 8'h00, "mode");
        chk_reg(FC, 8'hff, 8'h00, "ctrl");
        chk_reg(3'h7, 8'hff, 8'h00, "unmapped");
        wr_reg(FC, 8'hf8);
        chk_reg(MS, 8'hf9, 8'h00, "ignored");
        $display("test reset done");
    endtask : t_reset
    task automatic t_rx_trig;
        for (int c = 0; c < 4; c++) begin
            wr_reg(FC, {c[1:0], 6'h03});
            wr_reg(MSK, 8'h01);
            wr_reg(ST, 8'h07);
            feed(int'(RXT[c]) - 1, 8'h40);
            chk_reg(ST, 8'h01, 8'h00, "rx early");
            chk("rx_req_b", 8'h00, {7'h0, rx_req_b});
            feed(1, 8'h3f);
            settle(2);
            chk_reg(ST, 8'h01, 8'h01, "rx trig");
            chk("irq", 8'h01, {7'h0, irq});
            chk_reg(MS, 8'hc0, {c[1:0], 6'h00}, "rx sel");
        end
        feed(4, 8'h60);
        chk_reg(RXL, 8'hff, 8'h20, "rx full");
        feed(1, 8'h70);
        chk_reg(ST, 8'h04, 8'h04, "overrun");
        wr_reg(MSK, 8'h00);
        settle(2);
        chk("irq", 8'h00, {7'h0, irq});
        chk_reg(DAT, 8'hff, 8'h40, "rx head");
        wr_reg(ST, 8'h07);
        chk_reg(ST, 8'h05, 8'h00, "cleared");
        $display("test rx trigger done");
    endtask : t_rx_trig
    task automatic t_tx_trig;
        for (int c = 0; c < 4; c++) begin
            wr_reg(FC, {2'h0, c[1:0], 4'h5});
            for (int i = 0; i <= int'(TXT[c]); i++) wr_reg(DAT, 8'h80 + 8'(i));
            settle(3);
            wr_reg(ST, 8'h02);
            chk_reg(TXL, 8'hff, TXT[c], "tx level");
            chk_reg(ST, 8'h02, 8'h00, "tx above");
            chk("tx_req_b", 8'h01, {7'h0, tx_req_b});
            u_far.take(1);
            wait_idle(1'b0);
            chk_reg(ST, 8'h02, 8'h02, "tx below");
            drain <= 1'b1;
            wait_idle(1'b1);
            drain <= 1'b0;
            chk("tx_req_b", 8'h00, {7'h0, tx_req_b});
            chk("tx sent", TXT[c] + 8'h01, 8'(u_far.taken.size()));
            chk("tx first", 8'h80, u_far.taken[0]);
            chk("tx last", 8'h80 + TXT[c], u_far.taken[$]);
            u_far.taken.delete();
        end
        $display("test tx trigger done");
    endtask : t_tx_trig
    task automatic t_block;
        wr_reg(FC, 8'h1f);
        chk_reg(MS, 8'h08, 8'h08, "mode1");
        feed(7, 8'h20);
        settle(2);
        chk("rx below", 8'h01, {7'h0, rx_req_b});
        feed(1, 8'h27);
        settle(2);
        chk("rx at trig", 8'h00, {7'h0, rx_req_b});
        chk_reg(RXL, 8'hff, 8'h08, "rx level");
        for (int i = 0; i < 7; i++) chk_reg(DAT, 8'hff, 8'h20 + 8'(i), "rx data");
        settle(2);
        chk("rx last", 8'h00, {7'h0, rx_req_b});
        chk_reg(DAT, 8'hff, 8'h27, "rx data");
        settle(2);
        chk("rx empty", 8'h01, {7'h0, rx_req_b});
        chk_reg(RXL, 8'hff, 8'h00, "rx level");
        feed(1, 8'h30);
        rx_to <= 1'b1;
        settle(2);
        chk("rx timeout", 8'h00, {7'h0, rx_req_b});
        rx_to <= 1'b0;
        chk_reg(DAT, 8'hff, 8'h30, "rx data");
        for (int i = 0; i < 34; i++) wr_reg(DAT, 8'(i));
        settle(3);
        chk("tx full", 8'h01, {7'h0, tx_req_b});
        chk_reg(TXL, 8'hff, 8'h20, "tx level");
        u_far.take(24);
        wait_idle(1'b0);
        chk("tx at trig", 8'h01, {7'h0, tx_req_b});
        u_far.take(1);
        wait_idle(1'b0);
        chk("tx below", 8'h00, {7'h0, tx_req_b});
        chk_reg(TXL, 8'hff, 8'h07, "tx level");
        drain <= 1'b1;
        wait_idle(1'b1);
        drain <= 1'b0;
        chk("tx sent", 8'h21, 8'(u_far.taken.size()));
        $display("test block mode done");
    endtask : t_block
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        settle(1);
        t_reset();
        t_rx_trig();
        t_tx_trig();
        t_block();
        give_verdict();
    end
endmodule : uart_fifo_ctrl_bench
